//--- design/audio_serial_map.svh
// Offsets, field positions, reset values and timing counts.
`ifndef AUDIO_SERIAL_MAP_SVH
`define AUDIO_SERIAL_MAP_SVH
`define MAIN_FMT_IDX 16'h1055
`define CONV_FMT_IDX 16'h1056
`define OUT_WL_IDX 16'h1060
`define MAIN_DATA_IDX 16'h1061
`define CONV_DATA_IDX 16'h1062
`define STATUS_IDX 16'h1063
`define FMT_RESET 8'h00
`define OUT_WL_RESET 2'h0
`define DATA_VALID_BIT 31
`define SLOT_BITS 32
`define I2S_LAST_BIT 9'h018
`define LJ_LAST_BIT 9'h017
`define TDM_LAST_BIT 5'h18
`define TDM8_CHANNELS 5'h08
`define TDM16_CHANNELS 5'h10
`define STEREO_FRAME_BITS 9'h040
`define BIT_HALF_CYCLES 8'h04
`endif

//--- design/audio_serial_pkg.sv
// Types and shared decoding for the audio serial input ports.
package audio_serial_pkg;
  typedef enum logic [2:0] {
    MODE_I2S = 3'h0,
    MODE_LJ = 3'h1,
    MODE_TDM = 3'h2,
    MODE_RJ24 = 3'h3,
    MODE_RJ20 = 3'h4,
    MODE_RJ18 = 3'h5,
    MODE_RJ16 = 3'h6,
    MODE_RSV = 3'h7
  } mode_t;

  // For the main port hi[0] selects 16-channel TDM; for the converter
  // port hi[1:0] selects the data pin.
  typedef struct packed {
    logic [2:0] hi;
    logic frame_pol;
    logic bit_pol;
    mode_t mode;
  } fmt_t;

  typedef enum logic [1:0] {
    WL_24 = 2'h0,
    WL_20 = 2'h1,
    WL_16 = 2'h2,
    WL_16_ALT = 2'h3
  } word_len_t;

  function automatic logic [4:0] rj_bits(input mode_t m);
    unique case (m)
      MODE_RJ24: rj_bits = 5'h18;
      MODE_RJ20: rj_bits = 5'h14;
      MODE_RJ18: rj_bits = 5'h12;
      MODE_RJ16: rj_bits = 5'h10;
      default: rj_bits = 5'h00;
    endcase
  endfunction
endpackage

//--- design/audio_serial_if.sv
// Serial audio link between the source and the receiving ports.
`timescale 1ns/10ps
`default_nettype none
interface audio_serial_if;
  logic main_frame_clk;
  logic main_bit_clk;
  logic conv_frame_clk;
  logic conv_bit_clk;
  logic [3:0] data_input;
  modport device (
    input main_frame_clk,
    input main_bit_clk,
    input conv_frame_clk,
    input conv_bit_clk,
    input data_input
  );
  modport host (
    output main_frame_clk,
    output main_bit_clk,
    output conv_frame_clk,
    output conv_bit_clk,
    output data_input
  );
endinterface
`default_nettype wire

//--- design/audio_serial_device.sv
// Receiving end: two serial input ports with Avalon-MM registers.
// What this block does
// (R1) Output word length code sets 24/20/16 bits.
// (R2) Main format register, 8 bits, resets zero.
// (R3) Main frame polarity clear means left low.
// (R4) Main bit polarity clear means falling change.
// (R5) Main modes I2S, left-justified, TDM 8/16.
// (R6) Main right-justified 24/20/18/16; 111 reserved.
// (R7) Converter data pin chosen by bits 6:5.
// (R8) Converter frame polarity set means left high.
// (R9) Converter bit polarity set means rising change.
// (R10) Converter modes as main, TDM reserved.
// (R11) Converter format register, 8 bits, resets zero.
// (R12) Sample on edge opposite the change edge.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "audio_serial_map.svh"
module serial_in_rx #(
  parameter bit HAS_TDM = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire audio_serial_pkg::fmt_t fmt,
  input wire logic frame_pin,
  input wire logic bit_pin,
  input wire logic data_pin,
  input wire logic out_pop,
  output logic out_valid,
  output logic [27:0] out_entry,
  output logic overrun
);
  import audio_serial_pkg::*;
  typedef struct packed {
    logic [2:0] bit_s;
    logic [1:0] frame_s;
    logic [1:0] data_s;
    logic frame_prev;
    logic started;
    logic [8:0] bit_idx;
    logic [31:0] shift;
    logic [1:0][27:0] entries;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic overrun;
  } rx_state_t;
  rx_state_t r_reg;
  rx_state_t r_next;

  always_comb begin
    logic samp;
    logic lr;
    logic d;
    logic left;
    logic tdm;
    logic new_ch;
    logic push;
    logic pop;
    logic [4:0] rjn;
    logic [4:0] chans;
    logic [8:0] idx;
    logic [27:0] entry;
    samp = 1'b0;
    lr = r_reg.frame_s[1];
    d = r_reg.data_s[1];
    left = 1'b0;
    tdm = 1'b0;
    new_ch = 1'b0;
    push = 1'b0;
    pop = out_pop && (r_reg.count != 2'h0);
    rjn = rj_bits(fmt.mode);
    chans = fmt.hi[0] ? `TDM16_CHANNELS : `TDM8_CHANNELS; // [R5]
    idx = r_reg.bit_idx;
    entry = '0;
    r_next = r_reg;
    r_next.bit_s = {r_reg.bit_s[1:0], bit_pin};
    r_next.frame_s = {r_reg.frame_s[0], frame_pin};
    r_next.data_s = {r_reg.data_s[0], data_pin};
    r_next.overrun = 1'b0;
    // Rising edge when data changes on falling, and the reverse.
    samp = fmt.bit_pol ? (!r_reg.bit_s[1] && r_reg.bit_s[2]) // [R12]
                       : (r_reg.bit_s[1] && !r_reg.bit_s[2]); // [R4] [R9]
    if (samp) begin
      left = (lr == fmt.frame_pol); // [R3] [R8]
      tdm = HAS_TDM && (fmt.mode == MODE_TDM); // [R5] [R10]
      if (tdm) begin
        new_ch = left && (r_reg.frame_prev != fmt.frame_pol);
      end else begin
        new_ch = (lr != r_reg.frame_prev);
      end
      r_next.frame_prev = lr;
      // A right-justified word ends where its channel ends.
      if (new_ch && r_reg.started && (rjn != 5'h00)) begin
        push = 1'b1;
        entry = {3'h0, left, r_reg.shift[23:0] << (5'h18 - rjn)}; // [R6]
      end
      r_next.shift = {r_reg.shift[30:0], d};
      if (new_ch) begin
        idx = 9'h000;
        r_next.started = 1'b1;
      end else if (r_reg.bit_idx != 9'h1ff) begin
        idx = r_reg.bit_idx + 9'h001;
      end
      r_next.bit_idx = idx;
      if (r_reg.started || new_ch) begin
        if (tdm) begin
          if (idx[4:0] == `TDM_LAST_BIT && {1'b0, idx[8:5]} < chans) begin
            push = 1'b1;
            entry = {idx[8:5], r_reg.shift[22:0], d}; // [R5]
          end
        end else if ((fmt.mode == MODE_I2S && idx == `I2S_LAST_BIT) ||
                     (fmt.mode == MODE_LJ && idx == `LJ_LAST_BIT)) begin
          push = 1'b1;
          entry = {3'h0, !left, r_reg.shift[22:0], d}; // [R5] [R10]
        end
      end
    end
    // The serial source cannot stall, so a full buffer drops the word.
    if (push && r_reg.count == 2'h2 && !pop) begin
      r_next.overrun = 1'b1;
    end else if (push) begin
      r_next.entries[r_reg.wr_ptr] = entry;
      r_next.wr_ptr = !r_reg.wr_ptr;
    end
    if (pop) begin
      r_next.rd_ptr = !r_reg.rd_ptr;
    end
    r_next.count = r_reg.count + {1'b0, push && !r_next.overrun}
                   - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign out_valid = (r_reg.count != 2'h0);
  assign out_entry = r_reg.entries[r_reg.rd_ptr];
  assign overrun = r_reg.overrun;
endmodule // serial_in_rx

module audio_serial_device (
  input wire logic clk,
  input wire logic nrst,
  audio_serial_if.device link,
  input wire logic [15:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);
  import audio_serial_pkg::*;
  typedef struct packed {
    fmt_t main_fmt;
    fmt_t conv_fmt;
    word_len_t out_wl;
    logic [1:0] overrun;
    logic [1:0] pop;
    logic wait_bit;
    logic [31:0] rdata;
    logic [1:0][7:0] pin_s;
  } dev_state_t;
  dev_state_t r_reg;
  dev_state_t r_next;
  logic main_valid;
  logic conv_valid;
  logic [27:0] main_entry;
  logic [27:0] conv_entry;
  logic main_ovr;
  logic conv_ovr;
  logic conv_pin;

  function automatic logic [31:0] data_word(input logic valid,
      input logic [27:0] e, input word_len_t wl);
    logic [23:0] w;
    w = e[23:0];
    unique case (wl)
      WL_24: w = e[23:0];
      WL_20: w = {e[23:4], 4'h0};
      WL_16, WL_16_ALT: w = {e[23:8], 8'h00};
    endcase
    data_word = '0;
    data_word[`DATA_VALID_BIT] = valid;
    data_word[27:0] = {e[27:24], w};
  endfunction

  assign conv_pin = r_reg.pin_s[1][~r_reg.conv_fmt.hi[1:0]]; // [R7]

  serial_in_rx #(.HAS_TDM(1'b1)) main_rx (
    .clk(clk),
    .nrst(nrst),
    .fmt(r_reg.main_fmt),
    .frame_pin(r_reg.pin_s[1][4]),
    .bit_pin(r_reg.pin_s[1][5]),
    .data_pin(r_reg.pin_s[1][0]),
    .out_pop(r_reg.pop[0]),
    .out_valid(main_valid),
    .out_entry(main_entry),
    .overrun(main_ovr)
  );

  serial_in_rx #(.HAS_TDM(1'b0)) conv_rx (
    .clk(clk),
    .nrst(nrst),
    .fmt(r_reg.conv_fmt),
    .frame_pin(r_reg.pin_s[1][6]),
    .bit_pin(r_reg.pin_s[1][7]),
    .data_pin(conv_pin),
    .out_pop(r_reg.pop[1]),
    .out_valid(conv_valid),
    .out_entry(conv_entry),
    .overrun(conv_ovr)
  );

  always_comb begin
    logic hit;
    logic [15:0] idx;
    logic [1:0] clr;
    hit = (read || write) && r_reg.wait_bit;
    idx = {2'h0, address[15:2]};
    clr = 2'h0;
    r_next = r_reg;
    r_next.wait_bit = !hit;
    r_next.pop = 2'h0;
    r_next.pin_s = {r_reg.pin_s[0], link.conv_bit_clk, link.conv_frame_clk,
                    link.main_bit_clk, link.main_frame_clk, link.data_input};
    if (hit && read) begin
      r_next.rdata = '0;
      if (address[1:0] == 2'h0) begin
        unique case (idx)
          `MAIN_FMT_IDX: r_next.rdata[7:0] = r_reg.main_fmt;
          `CONV_FMT_IDX: r_next.rdata[7:0] = r_reg.conv_fmt;
          `OUT_WL_IDX: r_next.rdata[1:0] = r_reg.out_wl;
          `MAIN_DATA_IDX: begin
            r_next.rdata = data_word(main_valid, main_entry,
                                     r_reg.out_wl); // [R1]
            r_next.pop[0] = main_valid;
          end
          `CONV_DATA_IDX: begin
            r_next.rdata = data_word(conv_valid, conv_entry,
                                     r_reg.out_wl); // [R1]
            r_next.pop[1] = conv_valid;
          end
          `STATUS_IDX: r_next.rdata[1:0] = r_reg.overrun;
          default: r_next.rdata = '0;
        endcase
      end
    end
    if (hit && write && byteenable[0] && address[1:0] == 2'h0) begin
      unique case (idx)
        `MAIN_FMT_IDX: r_next.main_fmt = fmt_t'(writedata[7:0]); // [R2]
        `CONV_FMT_IDX: r_next.conv_fmt = fmt_t'(writedata[7:0]); // [R11]
        `OUT_WL_IDX: r_next.out_wl = word_len_t'(writedata[1:0]); // [R1]
        `STATUS_IDX: clr = writedata[1:0];
        default: clr = 2'h0;
      endcase
    end
    // A new overrun in the clearing cycle stays set.
    r_next.overrun = (r_reg.overrun & ~clr) | {conv_ovr, main_ovr};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
      r_reg.main_fmt <= fmt_t'(`FMT_RESET); // [R2]
      r_reg.conv_fmt <= fmt_t'(`FMT_RESET); // [R11]
      r_reg.out_wl <= word_len_t'(`OUT_WL_RESET);
      r_reg.wait_bit <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign readdata = r_reg.rdata;
  assign waitrequest = r_reg.wait_bit;
endmodule // audio_serial_device
`default_nettype wire

//--- design/audio_serial_host.sv
// Source end: makes bit and frame clocks and sends serial words.
`timescale 1ns/10ps
`default_nettype none
`include "audio_serial_map.svh"
module serial_out_tx #(
  parameter bit HAS_TDM = 1'b1,
  parameter logic [7:0] HALF_CYCLES = `BIT_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire audio_serial_pkg::fmt_t fmt,
  input wire logic [23:0] word,
  input wire logic word_valid,
  output logic word_ready,
  output logic bit_out,
  output logic frame_out,
  output logic data_out
);
  import audio_serial_pkg::*;
  typedef struct packed {
    logic [7:0] div;
    logic bclk;
    logic lr;
    logic dout;
    logic [8:0] pos;
    logic [23:0] cur;
    logic [23:0] hold;
    logic hold_full;
    logic ready;
  } tx_state_t;
  tx_state_t r_reg;
  tx_state_t r_next;

  always_comb begin
    logic change;
    logic tdm;
    logic [9:0] flen;
    logic [8:0] p;
    logic [5:0] off;
    logic [5:0] len;
    logic [5:0] k;
    logic [23:0] w;
    r_next = r_reg;
    change = 1'b0;
    tdm = HAS_TDM && (fmt.mode == MODE_TDM);
    // A slot is 32 bit clocks, so the channel count moves up five places.
    flen = tdm ? {fmt.hi[0] ? `TDM16_CHANNELS : `TDM8_CHANNELS, 5'h00}
               : {1'b0, `STEREO_FRAME_BITS};
    p = r_reg.pos;
    off = 6'h00;
    len = 6'h00;
    k = 6'h00;
    w = r_reg.cur;
    if (r_reg.div == HALF_CYCLES - 8'h01) begin
      r_next.div = 8'h00;
      r_next.bclk = !r_reg.bclk;
      change = (r_reg.bclk != fmt.bit_pol); // [R4] [R9]
    end else begin
      r_next.div = r_reg.div + 8'h01;
    end
    if (change) begin
      p = ({1'b0, r_reg.pos} >= flen - 10'h001) ? 9'h000 : r_reg.pos + 9'h001;
      r_next.pos = p;
      if (p[4:0] == 5'h00) begin
        w = r_reg.hold_full ? r_reg.hold : 24'h0;
        r_next.cur = w;
        r_next.hold_full = 1'b0;
      end
      if (tdm) begin
        r_next.lr = (p[8:5] == 4'h0) ? fmt.frame_pol : !fmt.frame_pol;
      end else begin
        r_next.lr = p[5] ? !fmt.frame_pol : fmt.frame_pol; // [R3] [R8]
      end
      unique case (fmt.mode)
        MODE_I2S: begin off = 6'h01; len = 6'h18; end
        MODE_LJ: begin off = 6'h00; len = 6'h18; end
        MODE_TDM: begin off = 6'h01; len = tdm ? 6'h18 : 6'h00; end
        MODE_RSV: begin off = 6'h00; len = 6'h00; end
        default: begin
          len = {1'b0, rj_bits(fmt.mode)};
          off = 6'(`SLOT_BITS) - len;
        end
      endcase
      k = {1'b0, p[4:0]} - off;
      if ({1'b0, p[4:0]} >= off && k < len) begin
        r_next.dout = w[5'h17 - k[4:0]];
      end else begin
        r_next.dout = 1'b0;
      end
    end
    if (word_valid && r_reg.ready) begin
      r_next.hold = word;
      r_next.hold_full = 1'b1;
    end
    r_next.ready = !r_next.hold_full;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
      r_reg.pos <= 9'h1ff;
    end else begin
      r_reg <= r_next;
    end
  end

  assign word_ready = r_reg.ready;
  assign bit_out = r_reg.bclk;
  assign frame_out = r_reg.lr;
  assign data_out = r_reg.dout;
endmodule // serial_out_tx

module audio_serial_host #(
  parameter logic [7:0] HALF_CYCLES = `BIT_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  audio_serial_if.host link,
  input wire audio_serial_pkg::fmt_t main_fmt,
  input wire audio_serial_pkg::fmt_t conv_fmt,
  input wire logic [23:0] main_word,
  input wire logic main_word_valid,
  output logic main_word_ready,
  input wire logic [23:0] conv_word,
  input wire logic conv_word_valid,
  output logic conv_word_ready
);
  import audio_serial_pkg::*;
  typedef struct packed {
    logic [3:0] pins;
    logic [3:0] clks;
  } host_state_t;
  host_state_t r_reg;
  host_state_t r_next;
  logic [2:0] m_out;
  logic [2:0] c_out;

  serial_out_tx #(.HAS_TDM(1'b1), .HALF_CYCLES(HALF_CYCLES)) main_tx (
    .clk(clk),
    .nrst(nrst),
    .fmt(main_fmt),
    .word(main_word),
    .word_valid(main_word_valid),
    .word_ready(main_word_ready),
    .bit_out(m_out[2]),
    .frame_out(m_out[1]),
    .data_out(m_out[0])
  );

  serial_out_tx #(.HAS_TDM(1'b0), .HALF_CYCLES(HALF_CYCLES)) conv_tx (
    .clk(clk),
    .nrst(nrst),
    .fmt(conv_fmt),
    .word(conv_word),
    .word_valid(conv_word_valid),
    .word_ready(conv_word_ready),
    .bit_out(c_out[2]),
    .frame_out(c_out[1]),
    .data_out(c_out[0])
  );

  // The converter pin wins if both ports pick data input 0.
  always_comb begin
    r_next.clks = {c_out[2:1], m_out[2:1]};
    r_next.pins = {3'h0, m_out[0]};
    r_next.pins[~conv_fmt.hi[1:0]] = c_out[0]; // [R7]
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.main_bit_clk = r_reg.clks[1];
  assign link.main_frame_clk = r_reg.clks[0];
  assign link.conv_bit_clk = r_reg.clks[3];
  assign link.conv_frame_clk = r_reg.clks[2];
  assign link.data_input = r_reg.pins;
endmodule // audio_serial_host
`default_nettype wire

//--- testbench/audio_serial_monitor.sv
// Checker for the serial link between the source and the receiving ports.
`timescale 1ns/10ps
`default_nettype none
module audio_serial_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic main_frame_clk,
  input wire logic main_bit_clk,
  input wire logic conv_frame_clk,
  input wire logic conv_bit_clk,
  input wire logic [3:0] data_input,
  input wire audio_serial_pkg::fmt_t main_fmt,
  input wire audio_serial_pkg::fmt_t conv_fmt
);
  import audio_serial_pkg::*;
  logic [11:0] m_cnt, c_cnt;
  logic [1:0] m_seen, c_seen;
  logic m_prev, c_prev, m_chg, c_chg, conv_pin;
  fmt_t m_fmt_prev, c_fmt_prev;
  assign m_chg = main_frame_clk != m_prev;
  assign c_chg = conv_frame_clk != c_prev;
  assign conv_pin = data_input[2'h3 - conv_fmt.hi[1:0]];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Frame lengths are only judged after two clean frame edges under one
  // format, because a format change may cut a frame short.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      m_cnt <= 12'h0;
      c_cnt <= 12'h0;
      m_seen <= 2'h0;
      c_seen <= 2'h0;
      m_prev <= 1'b0;
      c_prev <= 1'b0;
      m_fmt_prev <= '0;
      c_fmt_prev <= '0;
    end else begin
      m_prev <= main_frame_clk;
      c_prev <= conv_frame_clk;
      m_fmt_prev <= main_fmt;
      c_fmt_prev <= conv_fmt;
      m_cnt <= m_chg ? 12'h0 : m_cnt + {11'h0, m_cnt != 12'hfff};
      c_cnt <= c_chg ? 12'h0 : c_cnt + {11'h0, c_cnt != 12'hfff};
      if (main_fmt != m_fmt_prev) m_seen <= 2'h0;
      else if (m_chg && m_seen != 2'h2) m_seen <= m_seen + 2'h1;
      if (conv_fmt != c_fmt_prev) c_seen <= 2'h0;
      else if (c_chg && c_seen != 2'h2) c_seen <= c_seen + 2'h1;
    end
  end
  // The host's pins trail its format inputs by two clocks, so edge checks
  // wait until the format has stood for three.
  a_main_data_edge: assert property ($changed(data_input[0]) &&
    main_fmt == $past(main_fmt, 3) && conv_fmt == $past(conv_fmt, 3) &&
    conv_fmt.hi[1:0] != 2'h3
    |-> (main_fmt.bit_pol ? $rose(main_bit_clk) : $fell(main_bit_clk)))
    else $error("main data moved off its change edge");
  a_main_frame_edge: assert property ($changed(main_frame_clk) &&
    main_fmt == $past(main_fmt, 3)
    |-> (main_fmt.bit_pol ? $rose(main_bit_clk) : $fell(main_bit_clk)))
    else $error("main frame clock moved off the change edge");
  a_conv_data_edge: assert property ($changed(conv_pin) &&
    conv_fmt == $past(conv_fmt, 3)
    |-> (conv_fmt.bit_pol ? $rose(conv_bit_clk) : $fell(conv_bit_clk)))
    else $error("converter data moved off its change edge");
  a_conv_frame_edge: assert property ($changed(conv_frame_clk) &&
    conv_fmt == $past(conv_fmt, 3)
    |-> (conv_fmt.bit_pol ? $rose(conv_bit_clk) : $fell(conv_bit_clk)))
    else $error("converter frame clock moved off the change edge");
  a_main_bit_half: assert property ($changed(main_bit_clk)
    |=> ($stable(main_bit_clk) || $changed(main_fmt))[*3])
    else $error("main bit clock phase too short");
  a_conv_bit_half: assert property ($changed(conv_bit_clk)
    |=> ($stable(conv_bit_clk) || $changed(conv_fmt))[*3])
    else $error("converter bit clock phase too short");
  a_main_frame_len: assert property (m_chg && m_seen == 2'h2 &&
    $stable(main_fmt) && main_fmt.mode != MODE_TDM &&
    main_fmt.mode != MODE_RSV |-> m_cnt == 12'h0ff)
    else $error("main channel is not 32 bit clocks long");
  a_tdm_slot_len: assert property (m_chg && m_seen == 2'h2 &&
    $stable(main_fmt) && main_fmt.mode == MODE_TDM &&
    main_frame_clk != main_fmt.frame_pol |-> m_cnt == 12'h0ff)
    else $error("first slot is not 32 bit clocks long");
  a_tdm_frame_len: assert property (m_chg && m_seen == 2'h2 &&
    $stable(main_fmt) && main_fmt.mode == MODE_TDM &&
    main_frame_clk == main_fmt.frame_pol
    |-> m_cnt == (main_fmt.hi[0] ? 12'heff : 12'h6ff))
    else $error("slot count in the frame is wrong");
  a_conv_frame_len: assert property (c_chg && c_seen == 2'h2 &&
    $stable(conv_fmt) && conv_fmt.mode != MODE_TDM &&
    conv_fmt.mode != MODE_RSV |-> c_cnt == 12'h0ff)
    else $error("converter channel is not 32 bit clocks long");
  c_tdm_frame: cover property (m_chg && main_fmt.mode == MODE_TDM);
  c_tdm16_frame: cover property (m_chg && main_fmt.hi[0]);
  c_conv_frame: cover property (c_chg && c_seen == 2'h2);
endmodule // audio_serial_monitor
`default_nettype wire

//--- testbench/audio_serial_port_format_config_tb.sv
// Bench joining both ends and checking registers and captured words.
`timescale 1ns/10ps
`default_nettype none
`include "audio_serial_map.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  n_fail++; $display("BAD %s exp %h got %h", nm, e, g); end end
module audio_serial_port_format_config_tb;
  import audio_serial_pkg::*;
  localparam logic [2:0] MAIN_M [10] = '{0, 1, 2, 7, 3, 4, 5, 0, 2, 6};
  localparam logic [2:0] CONV_M [10] = '{0, 1, 3, 4, 5, 6, 2, 0, 7, 1};
  logic clk, read = 1'b0, write = 1'b0, nrst = 1'b0, waitrequest;
  logic [15:0] address = 16'h0;
  logic [31:0] writedata = 32'h0, readdata;
  logic [3:0] byteenable = 4'hf;
  fmt_t main_fmt = '0, conv_fmt = '0;
  logic [23:0] main_word = 24'h0, conv_word = 24'h0;
  logic main_word_valid = 1'b0, conv_word_valid = 1'b0;
  logic main_word_ready, conv_word_ready;
  logic [63:0] exp_q[$];
  logic [63:0] note;
  int n_fail = 0;
  int check_count = 0;
  audio_serial_if link_bus();
  audio_serial_host i_audio_serial_host (.clk(clk), .nrst(nrst),
    .link(link_bus), .main_fmt(main_fmt), .conv_fmt(conv_fmt),
    .main_word(main_word), .main_word_valid(main_word_valid),
    .main_word_ready(main_word_ready), .conv_word(conv_word),
    .conv_word_valid(conv_word_valid), .conv_word_ready(conv_word_ready));
  audio_serial_device i_audio_serial_device (.clk(clk), .nrst(nrst),
    .link(link_bus), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));
  audio_serial_monitor i_audio_serial_monitor (.clk(clk), .nrst(nrst),
    .main_frame_clk(link_bus.main_frame_clk),
    .main_bit_clk(link_bus.main_bit_clk),
    .conv_frame_clk(link_bus.conv_frame_clk),
    .conv_bit_clk(link_bus.conv_bit_clk), .data_input(link_bus.data_input),
    .main_fmt(main_fmt), .conv_fmt(conv_fmt));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // The request is held until waitrequest is seen low at a rising edge.
  task automatic av(input logic wr, input logic [15:0] a,
      input logic [31:0] wd, input logic [3:0] be);
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= wd;
    byteenable <= be;
    for (int k = 0; k <= 50; k++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
      if (k == 50) begin
        n_fail++;
        report_and_stop();
      end
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // A zero mask still pops the data buffer but ignores the value.
  task automatic rd(input logic [15:0] a, input logic [31:0] e,
      input logic [31:0] m);
    exp_q.push_back({m, e & m});
    av(1'b0, a, 32'h0, 4'hf);
  endtask
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[63:32] != 32'h0)
        `CHK("readdata", note[31:0], readdata & note[63:32])
    end
  end
  function automatic logic [23:0] wmask(input logic [2:0] m,
      input logic [1:0] wl);
    int n;
    n = (m == 3'h4) ? 20 : (m == 3'h5) ? 18 : (m == 3'h6) ? 16 : 24;
    if (wl == 2'h1 && n > 20) n = 20;
    if (wl[1] && n > 16) n = 16;
    return 24'hffffff << (24 - n);
  endfunction
  task automatic run_case(input int i);
    logic [1:0] wl;
    logic mc, cc;
    fmt_t mf;
    fmt_t cf;
    wl = 2'($urandom);
    mc = MAIN_M[i] != 3'h7;
    cc = CONV_M[i] != 3'h7 && CONV_M[i] != 3'h2;
    // Formats are kept locally: the bus writes below must not see the
    // old values that the non-blocking updates have not replaced yet.
    mf = {2'($urandom), i == 8, 2'($urandom), MAIN_M[i]};
    cf = {1'($urandom), 2'(i), 2'($urandom), CONV_M[i]};
    @(posedge clk);
    main_fmt <= mf;
    conv_fmt <= cf;
    main_word <= 24'($urandom);
    conv_word <= 24'($urandom);
    main_word_valid <= 1'b1;
    conv_word_valid <= 1'b1;
    av(1'b1, `MAIN_FMT_IDX << 2, {24'($urandom), mf}, 4'hf);
    av(1'b1, `CONV_FMT_IDX << 2, {24'($urandom), cf}, 4'hf);
    av(1'b1, `OUT_WL_IDX << 2, {30'($urandom), wl}, 4'hf);
    rd(`MAIN_FMT_IDX << 2, {24'h0, mf}, '1);
    rd(`CONV_FMT_IDX << 2, {24'h0, cf}, '1);
    rd(`OUT_WL_IDX << 2, {30'h0, wl}, '1);
    repeat (5000) @(posedge clk);
    repeat (3) rd(`MAIN_DATA_IDX << 2, 32'h0, 32'h0);
    repeat (3) rd(`CONV_DATA_IDX << 2, 32'h0, 32'h0);
    av(1'b1, `STATUS_IDX << 2, 32'h3, 4'hf);
    repeat (1200) @(posedge clk);
    rd(`STATUS_IDX << 2, {30'h0, cc, mc}, 32'h3);
    rd(`MAIN_DATA_IDX << 2, {mc, 7'h0, main_word & wmask(MAIN_M[i], wl)},
      (i == 7) ? 32'h0 : {8'h80, {24{mc}}});
    rd(`CONV_DATA_IDX << 2, {cc, 7'h0, conv_word & wmask(CONV_M[i], wl)},
      {8'h80, {24{cc}}});
  endtask
  initial begin
    void'($urandom(59));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(`MAIN_FMT_IDX << 2, 32'h0, '1);
    rd(`CONV_FMT_IDX << 2, 32'h0, '1);
    rd(`OUT_WL_IDX << 2, 32'h0, '1);
    av(1'b1, `MAIN_FMT_IDX << 2, 32'h5a, 4'h0);
    rd(`MAIN_FMT_IDX << 2, 32'h0, '1);
    av(1'b1, (`CONV_FMT_IDX << 2) + 16'h1, 32'h5a, 4'hf);
    rd((`CONV_FMT_IDX << 2) + 16'h1, 32'h0, '1);
    rd(`CONV_FMT_IDX << 2, 32'h0, '1);
    rd(16'h1064 << 2, 32'h0, '1);
    for (int i = 0; i < 10; i++) run_case(i);
    report_and_stop();
  end
endmodule // audio_serial_port_format_config_tb
`default_nettype wire
